// [spx_datapath.v]
// Purpose: Packed pack, unpack, shift, extract and insert datapath
// Assumes: Decode supplies operands and immediate in one cycle
// Notes: Result registered, valid one cycle after request
//
// Overview of operation
// - Arithmetic doubleword shift fills with sign
// - 64-bit form packs four doublewords to words
// - 128-bit form packs eight doublewords to words
// - Pack sources are always treated signed
// - Words pack to unsigned saturated bytes
// - Unpack merges destination and source alternately
// - Word unpack places words in upper halves
// - Low doubleword unpack keeps low, adds source
// - High doubleword unpack moves high down
// - Extract word by two low immediate bits
// - Extract clears all bits above word
// - 128-bit extract writes low 8, 16, 32 or 64 bits by esize_i
// - Extract bytes to quadwords from 128 bits
// - Insert word from register or memory
// - Insert leaves unselected words unchanged
// - 128-bit insert writes selected element of esize_i size
// - Insert bytes, doublewords, quadwords into 128 bits
`timescale 1ns/1ps
`include "spx_map.vh"
module spx_datapath #(
  parameter GPR_W = 64
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire req_i,
  input wire [3:0] op_i,
  input wire wide_i,
  input wire [1:0] esize_i,
  input wire [7:0] imm_i,
  input wire [127:0] dst_i,
  input wire [127:0] src_i,
  input wire [63:0] gpr_i,
  input wire [63:0] mem_i,
  input wire use_mem_i,
  output reg valid_o,
  output reg [127:0] vec_o,
  output reg [GPR_W-1:0] gpr_o,
  output reg vec_we_o,
  output reg gpr_we_o
);
  // ****************************************
  // Element select helpers
  // ****************************************
  function [63:0] elem_get;
    input [127:0] v;
    input [1:0] es;
    input [3:0] idx;
    begin
      case (es)
        `SPX_ES_BYTE: elem_get = {56'h0, v[8*idx +: 8]};
        `SPX_ES_WORD: elem_get = {48'h0, v[16*idx[2:0] +: 16]};
        `SPX_ES_DWORD: elem_get = {32'h0, v[32*idx[1:0] +: 32]};
        default: elem_get = v[64*idx[0] +: 64];
      endcase
    end
  endfunction
  function [127:0] elem_put;
    input [127:0] v;
    input [1:0] es;
    input [3:0] idx;
    input [63:0] d;
    reg [127:0] t;
    begin
      t = v;
      case (es)
        `SPX_ES_BYTE: t[8*idx +: 8] = d[7:0];
        `SPX_ES_WORD: t[16*idx[2:0] +: 16] = d[15:0];
        `SPX_ES_DWORD: t[32*idx[1:0] +: 32] = d[31:0];
        default: t[64*idx[0] +: 64] = d;
      endcase
      elem_put = t;
    end
  endfunction
  // ****************************************
  // Lanes
  // ****************************************
  wire [63:0] lane_res [0:1];
  wire [63:0] lane_pdw [0:1];
  wire [63:0] lane_pub [0:1];
  wire [63:0] ldst [0:1];
  wire [63:0] lsrc [0:1];
  wire [5:0] shamt;
  wire uwide;
  assign shamt = (imm_i > 8'h3F) ? 6'h3F : imm_i[5:0];
  assign uwide = wide_i && ((op_i == `SPX_OP_UNPK_LWD) || (op_i == `SPX_OP_UNPK_HWD) ||
                            (op_i == `SPX_OP_UNPK_LBW) || (op_i == `SPX_OP_UNPK_HBW));
  // Word and byte unpack in 128-bit form: each lane sees one doubleword of each half
  assign ldst[0] = uwide ? {dst_i[95:64], dst_i[31:0]} : dst_i[63:0];
  assign lsrc[0] = uwide ? {src_i[95:64], src_i[31:0]} : src_i[63:0];
  assign ldst[1] = (wide_i && (op_i == `SPX_OP_SRAD)) ? dst_i[127:64] :
                   (wide_i ? {dst_i[127:96], dst_i[63:32]} : 64'h0);
  assign lsrc[1] = wide_i ? {src_i[127:96], src_i[63:32]} : 64'h0;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ln
      spx_lane u_lane (
        .op_i(op_i),
        .dst_i(ldst[g]),
        .src_i(lsrc[g]),
        .shamt_i(shamt),
        .res_o(lane_res[g]),
        .pack_dw_o(lane_pdw[g]),
        .pack_ub_o(lane_pub[g])
      );
    end
  endgenerate
  // Wide pack: separate lane on upper halves of each operand
  wire [63:0] hpdw;
  wire [63:0] hpub;
  spx_lane u_hi (
    .op_i(op_i),
    .dst_i(dst_i[127:64]),
    .src_i(src_i[127:64]),
    .shamt_i(shamt),
    .res_o(),
    .pack_dw_o(hpdw),
    .pack_ub_o(hpub)
  );
  // ****************************************
  // Result select
  // ****************************************
  reg [127:0] vec_next;
  reg [GPR_W-1:0] gpr_next;
  reg vwe_next;
  reg gwe_next;
  reg [63:0] ins_d;
  reg [63:0] ext_d;
  reg [127:0] ulo;
  reg [127:0] uhi;
  always @* begin
    vec_next = dst_i;
    gpr_next = {GPR_W{1'b0}};
    vwe_next = 1'b0;
    gwe_next = 1'b0;
    ins_d = use_mem_i ? mem_i : gpr_i;
    ext_d = 64'h0;
    ulo = {src_i[63:0], dst_i[63:0]};
    uhi = {src_i[127:64], dst_i[127:64]};
    case (op_i)
      `SPX_OP_SRAD: begin
        vwe_next = 1'b1;
        vec_next = wide_i ? {lane_res[1], lane_res[0]} : {64'h0, lane_res[0]};
      end
      `SPX_OP_PACK_DW_W: begin
        vwe_next = 1'b1;
        if (wide_i)
          vec_next = {hpdw[63:32], lane_pdw[0][63:32], hpdw[31:0], lane_pdw[0][31:0]};
        else
          vec_next = {64'h0, lane_pdw[0]};
      end
      `SPX_OP_PACK_W_UB: begin
        vwe_next = 1'b1;
        vec_next = wide_i ? {hpub[63:32], lane_pub[0][63:32], hpub[31:0], lane_pub[0][31:0]} :
                   {64'h0, lane_pub[0]};
      end
      `SPX_OP_UNPK_LWD, `SPX_OP_UNPK_HWD, `SPX_OP_UNPK_LBW, `SPX_OP_UNPK_HBW: begin
        vwe_next = 1'b1;
        vec_next = {64'h0, lane_res[0]};
        if (wide_i)
          vec_next = {lane_res[1], lane_res[0]};
      end
      `SPX_OP_UNPK_LDQ, `SPX_OP_UNPK_HDQ: begin
        vwe_next = 1'b1;
        vec_next = {64'h0, lane_res[0]};
        if (wide_i)
          vec_next = (op_i == `SPX_OP_UNPK_LDQ) ?
                     {src_i[63:32], dst_i[63:32], src_i[31:0], dst_i[31:0]} :
                     {src_i[127:96], dst_i[127:96], src_i[95:64], dst_i[95:64]};
      end
      `SPX_OP_UNPK_LQDQ: begin
        vwe_next = 1'b1;
        vec_next = {src_i[63:0], dst_i[63:0]};
      end
      `SPX_OP_UNPK_HQDQ: begin
        vwe_next = 1'b1;
        vec_next = {src_i[127:64], dst_i[127:64]};
      end
      `SPX_OP_EXTRACT: begin
        gwe_next = 1'b1;
        if (!wide_i)
          ext_d = elem_get({64'h0, src_i[63:0]}, `SPX_ES_WORD, {2'h0, imm_i[1:0]});
        else
          ext_d = elem_get(src_i, esize_i, imm_i[3:0]);
        gpr_next = ext_d[GPR_W-1:0];
      end
      `SPX_OP_INSERT: begin
        vwe_next = 1'b1;
        if (!wide_i)
          vec_next = elem_put(dst_i, `SPX_ES_WORD, {2'h0, imm_i[1:0]}, ins_d);
        else
          vec_next = elem_put(dst_i, esize_i, imm_i[3:0], ins_d);
      end
      default: begin
        vec_next = dst_i;
      end
    endcase
  end
  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_o <= 1'b0;
      vec_o <= 128'h0;
      gpr_o <= {GPR_W{1'b0}};
      vec_we_o <= 1'b0;
      gpr_we_o <= 1'b0;
    end else begin
      valid_o <= req_i;
      vec_we_o <= req_i & vwe_next;
      gpr_we_o <= req_i & gwe_next;
      if (req_i) begin
        vec_o <= vec_next;
        gpr_o <= gpr_next;
      end
    end
  end
endmodule

// [spx_map.vh]
// Purpose: Constants for the packed rearrangement datapath
// Assumes: Included by all datapath files but the saturation unit
// Notes: Opcode codes are local encodings
`ifndef SPX_MAP_VH
`define SPX_MAP_VH
`define SPX_OP_SRAD 4'h0
`define SPX_OP_PACK_DW_W 4'h1
`define SPX_OP_PACK_W_UB 4'h2
`define SPX_OP_UNPK_LWD 4'h3
`define SPX_OP_UNPK_HWD 4'h4
`define SPX_OP_UNPK_LDQ 4'h5
`define SPX_OP_UNPK_HDQ 4'h6
`define SPX_OP_EXTRACT 4'h7
`define SPX_OP_INSERT 4'h8
`define SPX_OP_UNPK_LBW 4'h9
`define SPX_OP_UNPK_HBW 4'hA
`define SPX_OP_UNPK_LQDQ 4'hB
`define SPX_OP_UNPK_HQDQ 4'hC
`define SPX_ES_BYTE 2'h0
`define SPX_ES_WORD 2'h1
`define SPX_ES_DWORD 2'h2
`define SPX_ES_QWORD 2'h3
`define SPX_LAT 1
`endif

// [spx_sat.v]
// Purpose: Signed saturation of one element to a narrower field
// Assumes: Input is signed two's complement
// Notes: Unsigned mode clamps to 0 .. 2^OW-1
`timescale 1ns/1ps
module spx_sat #(
  parameter IW = 32,
  parameter OW = 16
) (
  input wire [IW-1:0] val_i,
  input wire uns_i,
  output reg [OW-1:0] res_o
);
  wire signed [IW-1:0] sv;
  wire signed [IW-1:0] smax;
  wire signed [IW-1:0] smin;
  wire signed [IW-1:0] umax;
  assign sv = val_i;
  assign smax = {{(IW-OW+1){1'b0}}, {(OW-1){1'b1}}};
  assign smin = {{(IW-OW+1){1'b1}}, {(OW-1){1'b0}}};
  assign umax = {{(IW-OW){1'b0}}, {OW{1'b1}}};
  always @* begin
    if (uns_i) begin
      if (sv < 0)
        res_o = {OW{1'b0}};
      else if (sv > umax)
        res_o = {OW{1'b1}};
      else
        res_o = val_i[OW-1:0];
    end else begin
      if (sv > smax)
        res_o = smax[OW-1:0];
      else if (sv < smin)
        res_o = smin[OW-1:0];
      else
        res_o = val_i[OW-1:0];
    end
  end
endmodule

// [spx_lane.v]
// Purpose: One 64-bit lane of pack, shift and unpack logic
// Assumes: dst is the first operand, src the second
// Notes: Wide pack splits each lane's pack result across both output halves
`timescale 1ns/1ps
`include "spx_map.vh"
module spx_lane (
  input wire [3:0] op_i,
  input wire [63:0] dst_i,
  input wire [63:0] src_i,
  input wire [5:0] shamt_i,
  output reg [63:0] res_o,
  output wire [63:0] pack_dw_o,
  output wire [63:0] pack_ub_o
);
  wire [15:0] dw_w [0:3];
  wire [7:0] w_ub [0:7];
  wire [31:0] sh0;
  wire [31:0] sh1;
  wire [5:0] amt;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_dw
      spx_sat #(.IW(32), .OW(16)) u_d (
        .val_i(dst_i[32*g+31:32*g]),
        .uns_i(1'b0),
        .res_o(dw_w[g])
      );
      spx_sat #(.IW(32), .OW(16)) u_s (
        .val_i(src_i[32*g+31:32*g]),
        .uns_i(1'b0),
        .res_o(dw_w[g+2])
      );
    end
    for (g = 0; g < 4; g = g + 1) begin : g_wb
      spx_sat #(.IW(16), .OW(8)) u_d (
        .val_i(dst_i[16*g+15:16*g]),
        .uns_i(1'b1),
        .res_o(w_ub[g])
      );
      spx_sat #(.IW(16), .OW(8)) u_s (
        .val_i(src_i[16*g+15:16*g]),
        .uns_i(1'b1),
        .res_o(w_ub[g+4])
      );
    end
  endgenerate
  assign pack_dw_o = {dw_w[3], dw_w[2], dw_w[1], dw_w[0]};
  assign pack_ub_o = {w_ub[7], w_ub[6], w_ub[5], w_ub[4], w_ub[3], w_ub[2], w_ub[1], w_ub[0]};
  assign amt = (shamt_i > 6'h1F) ? 6'h1F : shamt_i;
  assign sh0 = $signed(dst_i[31:0]) >>> amt;
  assign sh1 = $signed(dst_i[63:32]) >>> amt;
  always @* begin
    case (op_i)
      `SPX_OP_SRAD: res_o = {sh1, sh0};
      `SPX_OP_UNPK_LWD: res_o = {src_i[31:16], dst_i[31:16],
                                 src_i[15:0], dst_i[15:0]};
      `SPX_OP_UNPK_HWD: res_o = {src_i[63:48], dst_i[63:48],
                                 src_i[47:32], dst_i[47:32]};
      `SPX_OP_UNPK_LBW: res_o = {src_i[31:24], dst_i[31:24], src_i[23:16], dst_i[23:16],
                                 src_i[15:8], dst_i[15:8], src_i[7:0], dst_i[7:0]};
      `SPX_OP_UNPK_HBW: res_o = {src_i[63:56], dst_i[63:56], src_i[55:48], dst_i[55:48],
                                 src_i[47:40], dst_i[47:40], src_i[39:32], dst_i[39:32]};
      `SPX_OP_UNPK_LDQ: res_o = {src_i[31:0], dst_i[31:0]};
      `SPX_OP_UNPK_HDQ: res_o = {src_i[63:32], dst_i[63:32]};
      default: res_o = dst_i;
    endcase
  end
endmodule

// [spx_datapath_checker.sv]
// Purpose: Port assertions for the packed datapath
// Assumes: Bound to spx_datapath
// Notes: Checks 64-bit forms only
`timescale 1ns/1ps
`include "spx_map.vh"
module spx_datapath_checker #(
  parameter GPR_W = 64
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire req_i,
  input wire [3:0] op_i,
  input wire wide_i,
  input wire [7:0] imm_i,
  input wire [127:0] dst_i,
  input wire [127:0] src_i,
  input wire [63:0] gpr_i,
  input wire use_mem_i,
  input wire [127:0] vec_o,
  input wire [GPR_W-1:0] gpr_o
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  wire nar = req_i && !wide_i;
  AST_SHIFT: assert property (
    nar && op_i == `SPX_OP_SRAD && imm_i == 8'h10 |=>
    vec_o[31:0] == {{16{$past(dst_i[31])}}, $past(dst_i[31:16])})
    else $error("Sign fill wrong");
  AST_PACK_PASS: assert property (
    nar && op_i == `SPX_OP_PACK_DW_W && dst_i[31:15] == 17'h0 |=>
    vec_o[15:0] == $past(dst_i[15:0]))
    else $error("In-range pack altered");
  AST_PACK_NEG: assert property (
    nar && op_i == `SPX_OP_PACK_DW_W && dst_i[63] && !(&dst_i[62:47]) |=>
    vec_o[31:16] == 16'h8000)
    else $error("Negative pack not clamped");
  AST_UB_NEG: assert property (
    nar && op_i == `SPX_OP_PACK_W_UB && dst_i[15] |=> vec_o[7:0] == 8'h00)
    else $error("Negative word not zero byte");
  AST_UNPK_LW: assert property (
    nar && op_i == `SPX_OP_UNPK_LWD |=>
    vec_o[31:0] == {$past(src_i[15:0]), $past(dst_i[15:0])})
    else $error("Word interleave wrong");
  AST_UNPK_LDQ: assert property (
    nar && op_i == `SPX_OP_UNPK_LDQ |=>
    vec_o[63:0] == {$past(src_i[31:0]), $past(dst_i[31:0])})
    else $error("Low dword unpack wrong");
  AST_UNPK_HDQ: assert property (
    nar && op_i == `SPX_OP_UNPK_HDQ |=>
    vec_o[63:0] == {$past(src_i[63:32]), $past(dst_i[63:32])})
    else $error("High dword unpack wrong");
  AST_EXT: assert property (
    nar && op_i == `SPX_OP_EXTRACT |=> gpr_o == {{(GPR_W-16){1'b0}},
    16'($past(src_i[63:0]) >> {$past(imm_i[1:0]), 4'h0})})
    else $error("Extract word wrong");
  AST_INS_KEEP: assert property (
    nar && op_i == `SPX_OP_INSERT && imm_i[1:0] == 2'h2 && !use_mem_i |=>
    vec_o[63:0] == {$past(dst_i[63:48]), $past(gpr_i[15:0]), $past(dst_i[31:0])})
    else $error("Insert disturbed words");
endmodule

// [spx_core_model.sv]
// Purpose: Decode and register file issuing one op
// Assumes: Request held for one clock
// Notes: Operands flip to inverse once taken
`timescale 1ns/1ps
module spx_core_model (
  input wire clk_i,
  output logic req_o,
  output logic [3:0] op_o,
  output logic wide_o,
  output logic [1:0] es_o,
  output logic [7:0] imm_o,
  output logic [127:0] dst_o,
  output logic [127:0] src_o,
  output logic [63:0] gpr_o,
  output logic [63:0] mem_o,
  output logic use_mem_o
);
  // ****
  // Issue
  // ****
  initial begin
    {req_o, op_o, wide_o, es_o, imm_o, dst_o, src_o, gpr_o, mem_o, use_mem_o} = '0;
  end
  task automatic issue(input logic [3:0] o, input logic w, input logic [1:0] e,
      input logic [7:0] i, input logic [127:0] d, input logic [127:0] s,
      input logic [63:0] g, input logic um);
    @(posedge clk_i);
    #1;
    {op_o, wide_o, es_o, imm_o, dst_o, src_o, gpr_o, mem_o, use_mem_o} =
      {o, w, e, i, d, s, g, ~g, um};
    req_o = 1'b1;
    @(posedge clk_i);
    #1;
    req_o = 1'b0;
    {dst_o, src_o, gpr_o, mem_o} = ~{dst_o, src_o, gpr_o, mem_o};
  endtask
endmodule

// [spx_datapath_test.sv]
// Purpose: Self-checking bench for the packed datapath
// Assumes: One clock, 50 ns period
// Notes: Memory operand is the inverse of the register operand
`timescale 1ns/1ps
`include "spx_map.vh"
module spx_datapath_test;
  logic clk_i;
  logic arst_n_i;
  logic req, wide, use_mem, valid, vwe, gwe;
  logic [3:0] op;
  logic [1:0] es;
  logic [7:0] imm;
  logic [127:0] dst, src, vec;
  logic [63:0] gpr, mem, gres;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [63:0] DA = 64'h4444_3333_2222_1111;
  localparam logic [63:0] SA = 64'h8888_7777_6666_5555;
  localparam logic [127:0] WV = 128'hFFEE_DDCC_BBAA_9988_7766_5544_3322_1100;
  // ****
  // Structure
  // ****
  spx_core_model u_core (.clk_i(clk_i), .req_o(req), .op_o(op), .wide_o(wide),
    .es_o(es), .imm_o(imm), .dst_o(dst), .src_o(src), .gpr_o(gpr), .mem_o(mem),
    .use_mem_o(use_mem));
  spx_datapath u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .op_i(op),
    .wide_i(wide), .esize_i(es), .imm_i(imm), .dst_i(dst), .src_i(src), .gpr_i(gpr),
    .mem_i(mem), .use_mem_i(use_mem), .valid_o(valid), .vec_o(vec), .gpr_o(gres),
    .vec_we_o(vwe), .gpr_we_o(gwe));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input logic [3:0] o, input logic w, input logic [1:0] e,
      input logic [7:0] i, input logic [127:0] d, input logic [127:0] s,
      input logic [63:0] g, input logic um);
    u_core.issue(o, w, e, i, d, s, g, um);
    chk("valid", {127'h0, valid}, 128'h1);
    chk("vec_we", {127'h0, vwe}, {127'h0, (o != `SPX_OP_EXTRACT) && (o <= `SPX_OP_UNPK_HQDQ)});
    chk("gpr_we", {127'h0, gwe}, {127'h0, o == `SPX_OP_EXTRACT});
  endtask
  task automatic t_pack();
    run(`SPX_OP_SRAD, 1'b0, 2'h0, 8'h10, {64'h0, 64'h8123_4567_7FFF_0001}, 0, 0, 0);
    chk("srad", vec, {64'h0, 64'hFFFF_8123_0000_7FFF});
    run(`SPX_OP_PACK_DW_W, 1'b0, 2'h0, 8'h00, {64'h0, 64'hFFFF_0000_0000_1234},
      {64'h0, 64'h0001_2345_FFFF_FFFE}, 0, 0);
    chk("packdw", vec, {64'h0, 64'h7FFF_FFFE_8000_1234});
    run(`SPX_OP_PACK_DW_W, 1'b1, 2'h0, 8'h00, {4{32'h0001_0000}}, {4{32'hFFFE_0000}}, 0, 0);
    chk("packdw_w", vec, {{4{16'h8000}}, {4{16'h7FFF}}});
    run(`SPX_OP_PACK_W_UB, 1'b0, 2'h0, 8'h00, {64'h0, 64'h0100_0080_007F_FFFF},
      {64'h0, 64'h0000_0001_8000_7FFF}, 0, 0);
    chk("packub", vec, {64'h0, 64'h0001_00FF_FF80_7F00});
  endtask
  task automatic t_unpack();
    logic [3:0] ops [4] = '{`SPX_OP_UNPK_LWD, `SPX_OP_UNPK_HWD, `SPX_OP_UNPK_LDQ,
      `SPX_OP_UNPK_HDQ};
    logic [63:0] exps [4] = '{64'h6666_2222_5555_1111, 64'h8888_4444_7777_3333,
      64'h6666_5555_2222_1111, 64'h8888_7777_4444_3333};
    for (int k = 0; k < 4; k++) begin
      run(ops[k], 1'b0, 2'h0, 8'h00, {64'h0, DA}, {64'h0, SA}, 0, 0);
      chk("unpack", vec, {64'h0, exps[k]});
    end
    run(`SPX_OP_UNPK_LWD, 1'b0, 2'h0, 8'h00, {64'h0, DA}, {64'h0, DA}, 0, 0);
    chk("unpack_same", vec, {64'h0, 64'h2222_2222_1111_1111});
    run(`SPX_OP_UNPK_HWD, 1'b1, 2'h0, 8'h00, WV, 0, 0, 0);
    chk("unpack_hw_w", vec, 128'h0000_FFEE_0000_DDCC_0000_BBAA_0000_9988);
    run(`SPX_OP_UNPK_LDQ, 1'b1, 2'h0, 8'h00, WV, 0, 0, 0);
    chk("unpack_ldq_w", vec, 128'h0000_0000_7766_5544_0000_0000_3322_1100);
    run(4'hF, 1'b0, 2'h0, 8'h00, {64'h0, DA}, {64'h0, SA}, 0, 0);
    chk("unknown_op", vec, {64'h0, DA});
  endtask
  task automatic t_elem();
    logic [127:0] msk;
    for (int k = 0; k < 4; k++) begin
      run(`SPX_OP_EXTRACT, 1'b0, 2'h1, 8'hFC | 8'(k), {64'h0, DA}, {64'h0, SA}, 0, 0);
      chk("extract", {64'h0, gres}, {112'h0, 16'(SA >> (16 * k))});
      run(`SPX_OP_EXTRACT, 1'b1, 2'(k), 8'h01, 0, WV, 0, 0);
      msk = (128'h1 << (8 << k)) - 128'h1;
      chk("extract_w", {64'h0, gres}, (WV >> (8 << k)) & msk);
      run(`SPX_OP_INSERT, 1'b1, 2'(k), 8'h01, WV, 0, 64'h0123_4567_89AB_CDEF, 0);
      msk = msk << (8 << k);
      chk("insert_w", vec, (WV & ~msk) | ((128'h0123_4567_89AB_CDEF << (8 << k)) & msk));
    end
    run(`SPX_OP_EXTRACT, 1'b1, 2'h1, 8'h05, 0, WV, 0, 0);
    chk("extract_w5", {64'h0, gres}, 128'hBBAA);
    run(`SPX_OP_INSERT, 1'b0, 2'h1, 8'h02, {64'h0, DA}, 0, 64'hDEAD_BEEF_0000_ABCD, 0);
    chk("insert", vec, {64'h0, 64'h4444_ABCD_2222_1111});
    run(`SPX_OP_INSERT, 1'b0, 2'h1, 8'h01, {64'h0, DA}, 0, ~64'h5A5A, 1'b1);
    chk("insert_mem", vec, {64'h0, 64'h4444_3333_5A5A_1111});
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    arst_n_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    chk("reset", {valid, vec[126:0]}, 128'h0);
    t_pack();
    t_unpack();
    t_elem();
    complete_run();
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
endmodule
bind spx_datapath spx_datapath_checker #(.GPR_W(GPR_W)) u_chk (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .req_i(req_i), .op_i(op_i), .wide_i(wide_i), .imm_i(imm_i),
  .dst_i(dst_i), .src_i(src_i), .gpr_i(gpr_i), .use_mem_i(use_mem_i), .vec_o(vec_o),
  .gpr_o(gpr_o));
